/* pkg/drlc_defs.svh */
// Constants of the dual register logic cell block: sizes, offsets, reset values
`ifndef DRLC_DEFS_SVH
`define DRLC_DEFS_SVH

`define DRLC_NUM_FF 20
`define DRLC_NUM_CELL 10
`define DRLC_ADDR_W 8
`define DRLC_DATA_W 32

`define DRLC_OFF_MODE 8'h00
`define DRLC_OFF_CSEL 8'h04
`define DRLC_OFF_SECURE 8'h08
`define DRLC_OFF_STATE 8'h0c
`define DRLC_OFF_PINS 8'h10

`define DRLC_SECURE_BIT 0

`define DRLC_RST_MODE 20'h00000
`define DRLC_RST_CSEL 20'h00000
`define DRLC_FUSE_SHOWN 20'hfffff

`define DRLC_SYNC_STAGES 2

`endif

/* pkg/drlc_pkg.sv */
// Types shared by the dual register logic cell block
`default_nettype none
`include "drlc_defs.svh"
package drlc_pkg;
  typedef logic [`DRLC_NUM_FF-1:0] drlc_vec_t;
  typedef logic [`DRLC_NUM_CELL-1:0] drlc_pin_t;
  typedef logic [`DRLC_ADDR_W-1:0] drlc_addr_t;
  typedef logic [`DRLC_DATA_W-1:0] drlc_data_t;
endpackage
`default_nettype wire

/* logic/drlc_sync.sv */
// Two-stage synchroniser for levels arriving from pins
`timescale 1ns/100ps
`default_nettype none
module drlc_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* logic/drlc_top.sv */
// Dual register logic cells: twenty D/T flip-flops, pin paths and config registers
`timescale 1ns/100ps
`default_nettype none
`include "drlc_defs.svh"

module drlc_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [`DRLC_ADDR_W-1:0] addr_i,
  input wire logic [`DRLC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`DRLC_DATA_W-1:0] rdata_o,
  input wire logic [`DRLC_NUM_FF-1:0] sum_term_i,
  input wire logic [`DRLC_NUM_FF-1:0] reset_term_i,
  input wire logic [`DRLC_NUM_FF-1:0] clock_term_i,
  input wire logic preset_i,
  input wire logic pin_clk_i,
  input wire logic [`DRLC_NUM_CELL-1:0] pin_in_i,
  input wire logic [`DRLC_NUM_CELL-1:0] oe_term_i,
  output logic [`DRLC_NUM_CELL-1:0] pin_out_o,
  output logic [`DRLC_NUM_CELL-1:0] pin_oe_n_o,
  output logic [`DRLC_NUM_CELL-1:0] pin_level_o,
  output logic [`DRLC_NUM_FF-1:0] feedback_o
);
  drlc_pkg::drlc_vec_t mode_reg;
  drlc_pkg::drlc_vec_t csel_reg;
  logic secure_reg;
  drlc_pkg::drlc_vec_t slave_reg;
  drlc_pkg::drlc_vec_t master_reg;
  drlc_pkg::drlc_vec_t prev_clk_reg;
  drlc_pkg::drlc_vec_t sel_clk;
  drlc_pkg::drlc_vec_t rise;
  drlc_pkg::drlc_vec_t d_next;
  logic pin_clk_sync;
  drlc_pkg::drlc_pin_t pin_sync;
  drlc_pkg::drlc_pin_t pin_drive;
  drlc_pkg::drlc_data_t rdata_next;
  drlc_pkg::drlc_vec_t shown_mode;
  drlc_pkg::drlc_vec_t shown_csel;

  // Pin clock is a pin, so it is synchronised before any edge detection
  drlc_sync #(
    .W(1)
  ) u_clk_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(pin_clk_i),
    .sync_o(pin_clk_sync)
  );

  // Dedicated input path from each I/O pin into the array
  drlc_sync #(
    .W(`DRLC_NUM_CELL)
  ) u_pin_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(pin_in_i),
    .sync_o(pin_sync)
  );

  // Pin levels leave through their own register, never mixed with feedback
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_level_o <= '0;
    end else begin
      pin_level_o <= pin_sync;
    end
  end

  // Type select: a one makes the flip-flop a toggle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_reg <= `DRLC_RST_MODE;
    end else if (wr_i && addr_i == `DRLC_OFF_MODE) begin
      mode_reg <= wdata_i[`DRLC_NUM_FF-1:0];
    end
  end

  // Clock source select: a one picks the pin clock
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      csel_reg <= `DRLC_RST_CSEL;
    end else if (wr_i && addr_i == `DRLC_OFF_CSEL) begin
      csel_reg <= wdata_i[`DRLC_NUM_FF-1:0];
    end
  end

  // Security fuse is one way; only a block reset erases it, as an erase would
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      secure_reg <= 1'b0;
    end else if (wr_i && addr_i == `DRLC_OFF_SECURE && wdata_i[`DRLC_SECURE_BIT]) begin
      secure_reg <= 1'b1;
    end
  end

  // Configuration is masked on readback once secured; writes still land unseen
  always_comb begin
    shown_mode = secure_reg ? `DRLC_FUSE_SHOWN : mode_reg;
    shown_csel = secure_reg ? `DRLC_FUSE_SHOWN : csel_reg;
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_next = '0;
    case (addr_i)
      `DRLC_OFF_MODE: begin
        rdata_next[`DRLC_NUM_FF-1:0] = shown_mode;
      end
      `DRLC_OFF_CSEL: begin
        rdata_next[`DRLC_NUM_FF-1:0] = shown_csel;
      end
      `DRLC_OFF_SECURE: begin
        rdata_next[`DRLC_SECURE_BIT] = secure_reg;
      end
      `DRLC_OFF_STATE: begin
        rdata_next[`DRLC_NUM_FF-1:0] = slave_reg;
      end
      `DRLC_OFF_PINS: begin
        rdata_next[`DRLC_NUM_CELL-1:0] = pin_level_o;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= '0;
    end
  end

  // Twenty flip-flops, each with private terms and config bits
  genvar k;
  for (k = 0; k < `DRLC_NUM_FF; k++) begin : g_ff
    // Per flip-flop clock mux, so registers may run on separate clocks
    assign sel_clk[k] = csel_reg[k] ? pin_clk_sync : clock_term_i[k];
    assign rise[k] = sel_clk[k] & ~prev_clk_reg[k];
    // Toggle mode flips the state when the sum term is high
    assign d_next[k] = mode_reg[k] ? (slave_reg[k] ^ sum_term_i[k]) : sum_term_i[k];

    // Edge detector history for the selected clock
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        prev_clk_reg[k] <= 1'b0;
      end else begin
        prev_clk_reg[k] <= sel_clk[k];
      end
    end

    // Master follows the data while the clock is low; reset clears it too
    always_ff @(posedge clk_i) begin
      if (reset_i || reset_term_i[k]) begin
        master_reg[k] <= 1'b0;
      end else if (!sel_clk[k]) begin
        master_reg[k] <= d_next[k];
      end
    end

    // Slave takes the master on a rising edge; the reset term needs no edge
    always_ff @(posedge clk_i) begin
      if (reset_i || reset_term_i[k]) begin
        slave_reg[k] <= 1'b0;
      end else if (rise[k]) begin
        // Preset only acts on an edge, so the array must pulse the clock term
        slave_reg[k] <= preset_i ? 1'b1 : master_reg[k];
      end
    end

    // Both stages of the flip-flop are empty one cycle after its reset term
    property p_reset_clears;
      @(posedge clk_i) disable iff (reset_i)
        reset_term_i[k] |=> (slave_reg[k] == 1'b0) && (master_reg[k] == 1'b0);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
      else $error("reset term left a stage set");

    // Reset term and preset on the same edge: the clear must win
    property p_reset_wins;
      @(posedge clk_i) disable iff (reset_i)
        (reset_term_i[k] && preset_i && rise[k]) |=> !feedback_o[k];
    endproperty
    a_reset_wins: assert property (p_reset_wins)
      else $error("preset beat the reset term");

    // Preset sets the flip-flop on its own detected edge
    property p_preset;
      @(posedge clk_i) disable iff (reset_i)
        (preset_i && rise[k] && !reset_term_i[k]) |=> feedback_o[k];
    endproperty
    a_preset: assert property (p_preset)
      else $error("preset did not set the flip-flop");

    // With no edge and no reset the stored state must not move
    property p_hold;
      @(posedge clk_i) disable iff (reset_i)
        (!rise[k] && !reset_term_i[k]) |=> $stable(slave_reg[k]);
    endproperty
    a_hold: assert property (p_hold)
      else $error("flip-flop changed without an edge");

    // Master is loaded from its own data term while the selected clock is low
    property p_master_follow;
      @(posedge clk_i) disable iff (reset_i)
        (!sel_clk[k] && !reset_term_i[k]) |=> master_reg[k] == $past(d_next[k]);
    endproperty
    a_master_follow: assert property (p_master_follow)
      else $error("master missed its data term");

    // D-type: the sum term of the cycle before the edge is what gets stored
    property p_dtype;
      @(posedge clk_i) disable iff (reset_i)
        (rise[k] && !preset_i && !reset_term_i[k] && !$past(mode_reg[k])
         && !$past(reset_i) && !$past(reset_term_i[k]))
        |=> slave_reg[k] == $past(sum_term_i[k], 2);
    endproperty
    a_dtype: assert property (p_dtype)
      else $error("D-type did not store the sum term");

    // T-type: the old state flips where the sum term was high
    property p_ttype;
      @(posedge clk_i) disable iff (reset_i)
        (rise[k] && !preset_i && !reset_term_i[k] && $past(mode_reg[k])
         && !$past(reset_i) && !$past(reset_term_i[k]))
        |=> slave_reg[k] == ($past(slave_reg[k], 2) ^ $past(sum_term_i[k], 2));
    endproperty
    a_ttype: assert property (p_ttype)
      else $error("T-type did not toggle");
  end

  // All twenty states feed back, buried ones as well as pin ones
  assign feedback_o = slave_reg;

  // Cell c drives pin c from its first flip-flop; the second is buried
  for (k = 0; k < `DRLC_NUM_CELL; k++) begin : g_cell
    assign pin_drive[k] = slave_reg[2 * k];
  end
  assign pin_out_o = pin_drive;

  // Each pin enable is registered from its own term; low means driving
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pin_oe_n_o <= {`DRLC_NUM_CELL{1'b1}};
    end else begin
      pin_oe_n_o <= ~oe_term_i;
    end
  end

  property p_pin_enable;
    @(posedge clk_i) disable iff (reset_i)
      !$past(reset_i) |-> pin_oe_n_o == ~$past(oe_term_i);
  endproperty
  a_pin_enable: assert property (p_pin_enable) else $error("pin enable not from its term");

  property p_pin_path;
    @(posedge clk_i) disable iff (reset_i)
      (!$past(reset_i) && !$past(reset_i, 2) && !$past(reset_i, 3))
      |-> pin_level_o == $past(pin_in_i, 3);
  endproperty
  a_pin_path: assert property (p_pin_path) else $error("pin level path wrong");

  property p_secure_read;
    @(posedge clk_i) disable iff (reset_i)
      (rd_i && secure_reg && (addr_i == `DRLC_OFF_MODE || addr_i == `DRLC_OFF_CSEL))
      |=> rdata_o[`DRLC_NUM_FF-1:0] == `DRLC_FUSE_SHOWN;
  endproperty
  a_secure_read: assert property (p_secure_read) else $error("secured config leaked");

  property p_open_read;
    @(posedge clk_i) disable iff (reset_i)
      (rd_i && !secure_reg && addr_i == `DRLC_OFF_MODE) |=> rdata_o == {12'h000, $past(mode_reg)};
  endproperty
  a_open_read: assert property (p_open_read) else $error("mode readback wrong");

  property p_read_one_cycle;
    @(posedge clk_i) disable iff (reset_i)
      !rd_i |=> rdata_o == '0;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("read data outlived slot");

  // Type bits land from the write data at the strobe edge
  property p_mode_write;
    @(posedge clk_i) disable iff (reset_i)
      (wr_i && addr_i == `DRLC_OFF_MODE) |=> mode_reg == $past(wdata_i[`DRLC_NUM_FF-1:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("type bits not written");

  // Clock source bits land from the write data at the strobe edge
  property p_csel_write;
    @(posedge clk_i) disable iff (reset_i)
      (wr_i && addr_i == `DRLC_OFF_CSEL) |=> csel_reg == $past(wdata_i[`DRLC_NUM_FF-1:0]);
  endproperty
  a_csel_write: assert property (p_csel_write) else $error("source bits not written");

  // Writing a one to the security bit arms the readback mask at once
  property p_secure_set;
    @(posedge clk_i) disable iff (reset_i)
      (wr_i && addr_i == `DRLC_OFF_SECURE && wdata_i[`DRLC_SECURE_BIT]) |=> secure_reg;
  endproperty
  a_secure_set: assert property (p_secure_set) else $error("security bit not set");

  // No write can disarm the mask; only a block reset does, as an erase would
  property p_secure_sticky;
    @(posedge clk_i) disable iff (reset_i)
      secure_reg |=> secure_reg;
  endproperty
  a_secure_sticky: assert property (p_secure_sticky) else $error("security bit fell");

  // Flip-flop states are never masked, so feedback stays observable when secured
  property p_state_read;
    @(posedge clk_i) disable iff (reset_i)
      (rd_i && addr_i == `DRLC_OFF_STATE) |=> rdata_o == {12'h000, $past(slave_reg)};
  endproperty
  a_state_read: assert property (p_state_read) else $error("state readback wrong");

  // Pin levels read back through their own path, apart from feedback
  property p_pin_read;
    @(posedge clk_i) disable iff (reset_i)
      (rd_i && addr_i == `DRLC_OFF_PINS) |=> rdata_o == {22'h000000, $past(pin_level_o)};
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin readback wrong");
endmodule
`default_nettype wire

/* tb/drlc_pins.sv */
// Model of the I/O pin wires between the cell drivers and an outside driver
`timescale 1ns/100ps
`default_nettype none
module drlc_pins (
  input wire logic clk_i,
  input wire drlc_pkg::drlc_pin_t pin_out_i,
  input wire drlc_pkg::drlc_pin_t pin_oe_n_i,
  input wire drlc_pkg::drlc_pin_t ext_i,
  input wire drlc_pkg::drlc_pin_t ext_en_i,
  output drlc_pkg::drlc_pin_t pin_o
);
  // Known start level, so an undriven wire never carries an unknown forward
  drlc_pkg::drlc_pin_t last_reg = '0;
  // Cell driver wins, then the outside driver; a floating line has no keeper,
  // so it shows the inverse of its last level rather than a lucky match
  assign pin_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_en_i & ext_i)
    | (pin_oe_n_i & ~ext_en_i & ~last_reg);
  // Last level seen on each wire, taken mid-cycle once the drivers have settled
  always @(negedge clk_i) begin
    last_reg <= pin_o;
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the dual register logic cells
`timescale 1ns/100ps
`default_nettype none
`include "drlc_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH %0t got %h want %h", $time, a, b); end end
module testbench;
  logic clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic preset_i = 1'b0, pin_clk_i = 1'b0;
  drlc_pkg::drlc_addr_t addr_i = 8'h00;
  drlc_pkg::drlc_data_t wdata_i = 32'h0, rdata_o, rv;
  drlc_pkg::drlc_vec_t sum_i = 20'h0, rst_t = 20'h0, clk_t = 20'h0, fb, ev;
  drlc_pkg::drlc_pin_t pin_in, oe_t = 10'h0, pout, poe_n, plevel;
  drlc_pkg::drlc_pin_t ext = 10'h0, ext_en = 10'h0;
  int bad_count = 0, tests_run = 0, cyc = 0;
  drlc_top drlc_top_inst (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sum_term_i(sum_i),
    .reset_term_i(rst_t), .clock_term_i(clk_t), .preset_i(preset_i), .pin_clk_i(pin_clk_i),
    .pin_in_i(pin_in), .oe_term_i(oe_t), .pin_out_o(pout), .pin_oe_n_o(poe_n),
    .pin_level_o(plevel), .feedback_o(fb));
  drlc_pins drlc_pins_inst (.clk_i(clk_i), .pin_out_i(pout), .pin_oe_n_i(poe_n),
    .ext_i(ext), .ext_en_i(ext_en), .pin_o(pin_in));
  // 125 MHz clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  // Hang guard: the whole sequence needs under a hundred cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic done(input string n);
    $display("test %s finished", n);
  endtask
  task automatic wr(input drlc_pkg::drlc_addr_t a, input drlc_pkg::drlc_data_t d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rdc(input drlc_pkg::drlc_addr_t a, input drlc_pkg::drlc_data_t e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
    `CHK(rv, e)
  endtask
  // Clock term low, one cycle high, low again; result settles two edges on
  task automatic pulse(input drlc_pkg::drlc_vec_t m, input drlc_pkg::drlc_vec_t s);
    @(posedge clk_i);
    sum_i <= s;
    clk_t <= 20'h0;
    @(posedge clk_i);
    clk_t <= m;
    @(posedge clk_i);
    clk_t <= 20'h0;
    @(posedge clk_i);
    #1;
  endtask
  // Expected state after an edge on the flops in m
  function automatic drlc_pkg::drlc_vec_t nxt(input drlc_pkg::drlc_vec_t q,
    input drlc_pkg::drlc_vec_t m, input drlc_pkg::drlc_vec_t s, input drlc_pkg::drlc_vec_t md);
    return (q & ~m) | (m & ((md & (q ^ s)) | (~md & s)));
  endfunction
  initial begin
    repeat (5) @(posedge clk_i);
    `CHK(poe_n, 10'h3ff)
    reset_i <= 1'b0;
    @(posedge clk_i);
    #1 `CHK(fb, 20'h0)
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h14, 32'h0);
    done("reset");
    pulse(20'hfffff, 20'ha5c3e);
    `CHK(fb, 20'ha5c3e)
    `CHK(pout, 10'h0e6)
    wr(8'h00, 32'h0f0f0);
    rdc(8'h00, 32'h0f0f0);
    ev = nxt(20'ha5c3e, 20'hfffff, 20'hfffff, 20'h0f0f0);
    pulse(20'hfffff, 20'hfffff);
    `CHK(fb, ev)
    ev = nxt(ev, 20'h00010, 20'h00000, 20'h0f0f0);
    pulse(20'h00010, 20'h00000);
    `CHK(fb, ev)
    done("dt_mode");
    // Pin clock on flops 8 to 11 only; it passes a two-stage synchroniser
    wr(8'h04, 32'h00f00);
    sum_i <= 20'h00a00;
    ev = nxt(ev, 20'h00f00, 20'h00a00, 20'h0f0f0);
    pin_clk_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    pin_clk_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    #1 `CHK(fb, ev)
    wr(8'h04, 32'h0);
    done("clock_source");
    preset_i <= 1'b1;
    pulse(20'hfffff, 20'h0);
    preset_i <= 1'b0;
    `CHK(fb, 20'hfffff)
    // Reset term with no flop clock at all
    @(posedge clk_i);
    rst_t <= 20'h0000f;
    @(posedge clk_i);
    rst_t <= 20'h0;
    @(posedge clk_i);
    #1 `CHK(fb, 20'hffff0)
    preset_i <= 1'b1;
    rst_t <= 20'h000f0;
    pulse(20'hfffff, 20'h0);
    preset_i <= 1'b0;
    rst_t <= 20'h0;
    `CHK(fb, 20'hfff0f)
    done("preset_reset");
    oe_t <= 10'h3ff;
    repeat (5) @(posedge clk_i);
    #1 `CHK(poe_n, 10'h000)
    `CHK(plevel, 10'h3f3)
    oe_t <= 10'h00f;
    ext <= 10'h2aa;
    ext_en <= 10'h3f0;
    repeat (5) @(posedge clk_i);
    #1 `CHK(poe_n, 10'h3f0)
    `CHK(plevel, 10'h2a3)
    `CHK(fb, 20'hfff0f)
    rdc(8'h10, 32'h2a3);
    done("pins");
    wr(8'h08, 32'h1);
    rdc(8'h00, 32'hfffff);
    rdc(8'h04, 32'hfffff);
    rdc(8'h08, 32'h1);
    rdc(8'h0c, 32'hfff0f);
    done("secure");
    end_of_test();
  end
endmodule
`default_nettype wire
